/* File: dv/cpb_sfr_bank_bench.sv */
// Self-checking bench for the pointer, stack and port register bank.
// Assumes the bank answers reads one cycle late and never stalls the bus.
`timescale 1ns/100ps

module cpb_sfr_bank_bench
  import cpb_pkg::*;
;
  logic           core_clk;
  logic           rst_n;
  cpb_bus_req_s   bus_req;
  logic [7:0]     rdata_reg;
  logic           stk_push;
  logic [7:0]     stk_push_data;
  logic           stk_pop;
  cpb_stack_ram_s stk_ram_reg;
  logic           data_pointer_primary_inc;
  logic [15:0]    data_pointer_primary_reg;
  logic [7:0]     port0_reg;
  logic [7:0]     p0_oe_reg;
  logic [7:0]     wake_reload_reg;
  logic           rpd_fuse_unprog;
  logic           p2_0_pin_in;
  int             err_total;
  int             samples_checked;
  int             cycles;
  logic [7:0]     rd_val;

  cpb_sfr_bank uut (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .bus_req         (bus_req),
    .rdata_reg       (rdata_reg),
    .stk_push        (stk_push),
    .stk_push_data   (stk_push_data),
    .stk_pop         (stk_pop),
    .stk_ram_reg     (stk_ram_reg),
    .data_pointer_primary_inc        (data_pointer_primary_inc),
    .data_pointer_primary_reg        (data_pointer_primary_reg),
    .port0_reg       (port0_reg),
    .p0_oe_reg       (p0_oe_reg),
    .wake_reload_reg (wake_reload_reg),
    .rpd_fuse_unprog (rpd_fuse_unprog),
    .p2_0_pin_in     (p2_0_pin_in)
  );

  always #10 core_clk = ~core_clk;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // A hang is cut short at 3000 cycles, well above the hundred or so cycles the tests need.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      end_sim();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk16

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d,
                        input logic b);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, bit_op: b};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, bit_op: 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
    d = rdata_reg;
  endtask : bus_rd

  task automatic bus_rd_bit(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, bit_op: 1'b1};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
    d = rdata_reg;
  endtask : bus_rd_bit

  // Write and read the same address on consecutive edges, with no gap.
  task automatic bus_wr_rd(input logic [7:0] a, input logic [7:0] w,
                           output logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0, bit_op: 1'b0};
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, bit_op: 1'b0};
    @(posedge core_clk);
    bus_req <= '0;
    #1;
    d = rdata_reg;
  endtask : bus_wr_rd

  task automatic t_reset_vals;
    bus_rd(ADDR_PORT0, rd_val);  chk8(rd_val, 8'hFF, "port0 reset");
    bus_rd(ADDR_STACK, rd_val);  chk8(rd_val, 8'h07, "sp reset");
    bus_rd(ADDR_PTR_LO, rd_val); chk8(rd_val, 8'h00, "lo reset");
    bus_rd(ADDR_PTR_HI, rd_val); chk8(rd_val, 8'h00, "hi reset");
    bus_rd(ADDR_WAKE, rd_val);   chk8(rd_val, 8'h00, "wake reset");
    chk8(p0_oe_reg, 8'h00, "pins float after reset");
    bus_rd(8'h85, rd_val);       chk8(rd_val, 8'h00, "unmapped read");
  endtask : t_reset_vals

  // Push lands one above the old pointer; pop reads the old pointer.
  task automatic t_stack;
    @(posedge core_clk);
    stk_push      <= 1'b1;
    stk_push_data <= 8'h11;
    @(posedge core_clk);
    stk_push <= 1'b0;
    #1;
    chk8({7'h00, stk_ram_reg.we}, 8'h01, "push we");
    chk8(stk_ram_reg.addr, 8'h08, "push addr");
    chk8(stk_ram_reg.data, 8'h11, "push data");
    bus_rd(ADDR_STACK, rd_val); chk8(rd_val, 8'h08, "sp after push");
    @(posedge core_clk);
    stk_pop <= 1'b1;
    @(posedge core_clk);
    stk_pop <= 1'b0;
    #1;
    chk8({7'h00, stk_ram_reg.re}, 8'h01, "pop re");
    chk8(stk_ram_reg.addr, 8'h08, "pop addr");
    bus_wr(ADDR_STACK, 8'h3C, 1'b0);
    bus_rd(ADDR_STACK, rd_val); chk8(rd_val, 8'h3C, "sp write");
  endtask : t_stack

  task automatic t_pointers;
    bus_wr(ADDR_PTR_LO, 8'hFF, 1'b0);
    bus_wr(ADDR_PTR_HI, 8'h12, 1'b0);
    chk16(data_pointer_primary_reg, 16'h12FF, "ptr pair");
    @(posedge core_clk);
    data_pointer_primary_inc <= 1'b1;
    @(posedge core_clk);
    data_pointer_primary_inc <= 1'b0;
    #1;
    chk16(data_pointer_primary_reg, 16'h1300, "ptr carry");
    bus_wr(ADDR_AUX1, 8'h01, 1'b0);
    chk16(data_pointer_primary_reg, 16'h0000, "second ptr");
    bus_rd(ADDR_AUX1, rd_val); chk8(rd_val, 8'h01, "aux read");
    bus_wr(ADDR_PTR_LO, 8'hAA, 1'b0);
    bus_rd(ADDR_PTR_LO, rd_val); chk8(rd_val, 8'hAA, "second lo");
    bus_wr(ADDR_AUX1, 8'h00, 1'b0);
    chk16(data_pointer_primary_reg, 16'h1300, "first ptr kept");
    bus_rd(ADDR_PTR_HI, rd_val); chk8(rd_val, 8'h13, "first hi");
  endtask : t_pointers

  task automatic t_wake_port;
    bus_wr(ADDR_WAKE, 8'hA5, 1'b0);
    chk8(wake_reload_reg, 8'hA5, "wake out");
    bus_rd(ADDR_WAKE, rd_val); chk8(rd_val, 8'hA5, "wake read");
    bus_wr_rd(ADDR_WAKE, 8'h5A, rd_val);
    chk8(rd_val, 8'h5A, "wake back to back");
    bus_wr(ADDR_P0_DRIVE, 8'h0F, 1'b0);
    chk8(p0_oe_reg, 8'h0F, "pin drive on");
    bus_rd(ADDR_P0_DRIVE, rd_val); chk8(rd_val, 8'h0F, "drive read");
    bus_wr(ADDR_PORT0, 8'h55, 1'b0);
    bus_rd(ADDR_PORT0, rd_val); chk8(rd_val, 8'h55, "port0 rw");
    for (int i = 0; i < 8; i++) begin
      bus_wr({BIT_PAGE_PORT0, i[2:0]}, 8'h01, 1'b1);
      chk8(port0_reg, 8'h55 | (8'hFF >> (7 - i)), "bit set");
    end
    bus_wr(8'h87, 8'h00, 1'b1);
    chk8(port0_reg, 8'h7F, "bit clear");
    bus_rd_bit(8'h87, rd_val); chk8(rd_val, 8'h00, "bit read 7");
    bus_rd_bit(8'h86, rd_val); chk8(rd_val, 8'h01, "bit read 6");
  endtask : t_wake_port

  task automatic t_port2;
    @(posedge core_clk);
    p2_0_pin_in     <= 1'b1;
    rpd_fuse_unprog <= 1'b1;
    bus_rd(ADDR_PORT2, rd_val); chk8(rd_val, 8'h00, "p2.0 fuse");
    bus_rd_bit({BIT_PAGE_PORT2, 3'h0}, rd_val);
    chk8(rd_val, 8'h00, "p2.0 bit fuse");
    @(posedge core_clk);
    rpd_fuse_unprog <= 1'b0;
    bus_rd(ADDR_PORT2, rd_val); chk8(rd_val, 8'h01, "p2.0 pin");
    bus_rd_bit({BIT_PAGE_PORT2, 3'h0}, rd_val);
    chk8(rd_val, 8'h01, "p2.0 bit pin");
  endtask : t_port2

  initial begin
    core_clk        = 1'b0;
    rst_n           = 1'b0;
    bus_req         = '0;
    stk_push        = 1'b0;
    stk_push_data   = 8'h00;
    stk_pop         = 1'b0;
    data_pointer_primary_inc        = 1'b0;
    rpd_fuse_unprog = 1'b1;
    p2_0_pin_in     = 1'b0;
    err_total       = 0;
    samples_checked = 0;
    cycles          = 0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset_vals();
    t_stack();
    t_pointers();
    t_wake_port();
    t_port2();
    end_sim();
  end
endmodule : cpb_sfr_bank_bench

/* File: verilog/cpb_pkg.sv */
// Constants and carrier types for the core pointer and port register bank.
// Assumes an 8-bit special function register space reached by the core.
package cpb_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PTR_W  = 16;
  localparam int unsigned NUM_PTR = 2;

  // Byte addresses in the special function register space.
  localparam logic [7:0] ADDR_PORT0    = 8'h80;
  localparam logic [7:0] ADDR_STACK    = 8'h81;
  localparam logic [7:0] ADDR_PTR_LO   = 8'h82;
  localparam logic [7:0] ADDR_PTR_HI   = 8'h83;
  localparam logic [7:0] ADDR_WAKE     = 8'h86;
  localparam logic [7:0] ADDR_PORT2    = 8'hA0;
  localparam logic [7:0] ADDR_AUX1     = 8'hA2;
  localparam logic [7:0] ADDR_P0_DRIVE = 8'hFE;

  // Bit addresses: upper five bits pick the register, lower three the bit.
  localparam logic [4:0] BIT_PAGE_PORT0 = 5'h10;
  localparam logic [4:0] BIT_PAGE_PORT2 = 5'h14;
  localparam int unsigned BIT_IDX_W     = 3;

  // Field positions.
  localparam int unsigned AUX_SEL_POS  = 0;
  localparam int unsigned P2_BIT0_POS  = 0;

  // Reset values.
  localparam logic [7:0]  RST_PORT0    = 8'hFF;
  localparam logic [7:0]  RST_STACK    = 8'h07;
  localparam logic [15:0] RST_PTR      = 16'h0000;
  localparam logic [7:0]  RST_WAKE     = 8'h00;
  localparam logic [7:0]  RST_P0_DRIVE = 8'h00;
  localparam logic        RST_SEL      = 1'b0;

  localparam logic [7:0]  STACK_STEP   = 8'h01;
  localparam logic [15:0] PTR_STEP     = 16'h0001;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       bit_op;
  } cpb_bus_req_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       we;
    logic       re;
  } cpb_stack_ram_s;

endpackage : cpb_pkg

/* File: verilog/cpb_sfr_bank.sv */
// Stack pointer, dual data pointer, port 0 latch and wake-up reload bank.
// Assumes a single core master on the register port, synchronous to
// core_clk, and an external scratch-pad RAM driven by the stack port.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps

module cpb_sfr_bank
  import cpb_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           rst_n,
  input  wire cpb_bus_req_s   bus_req,
  output      logic [7:0]     rdata_reg,
  input  wire logic           stk_push,
  input  wire logic [7:0]     stk_push_data,
  input  wire logic           stk_pop,
  output      cpb_stack_ram_s stk_ram_reg,
  input  wire logic           data_pointer_primary_inc,
  output      logic [15:0]    data_pointer_primary_reg,
  output      logic [7:0]     port0_reg,
  output      logic [7:0]     p0_oe_reg,
  output      logic [7:0]     wake_reload_reg,
  input  wire logic           rpd_fuse_unprog,
  input  wire logic           p2_0_pin_in
);

  logic [7:0]  sp_reg;
  logic [15:0] ptr_reg  [NUM_PTR];
  logic [15:0] ptr_next [NUM_PTR];
  logic        sel_reg;
  logic        sel_next;
  logic [7:0]  rdata_next;
  logic        p2_bit0_val;

  logic byte_wr;
  logic byte_rd;
  logic bit_wr;
  logic bit_rd;
  logic [4:0] bit_page;
  logic [BIT_IDX_W-1:0] bit_idx;

  assign byte_wr  = bus_req.wr & ~bus_req.bit_op;
  assign byte_rd  = bus_req.rd & ~bus_req.bit_op;
  assign bit_wr   = bus_req.wr & bus_req.bit_op;
  assign bit_rd   = bus_req.rd & bus_req.bit_op;
  assign bit_page = bus_req.addr[7:3];
  assign bit_idx  = bus_req.addr[BIT_IDX_W-1:0];

  // Stack pointer and scratch-pad RAM port. A push beats a pop in the
  // same cycle, and both beat a software write, so the core's own stack
  // traffic is never lost to a stray register store.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_reg      <= RST_STACK;
      stk_ram_reg <= '0;
    end else if (stk_push) begin
      sp_reg           <= 8'(sp_reg + STACK_STEP);
      stk_ram_reg.addr <= 8'(sp_reg + STACK_STEP);
      stk_ram_reg.data <= stk_push_data;
      stk_ram_reg.we   <= 1'b1;
      stk_ram_reg.re   <= 1'b0;
    end else if (stk_pop) begin
      sp_reg           <= 8'(sp_reg - STACK_STEP);
      stk_ram_reg.addr <= sp_reg;
      stk_ram_reg.data <= BYTE_ZERO;
      stk_ram_reg.we   <= 1'b0;
      stk_ram_reg.re   <= 1'b1;
    end else begin
      stk_ram_reg.we <= 1'b0;
      stk_ram_reg.re <= 1'b0;
      if (byte_wr && bus_req.addr == ADDR_STACK) begin
        sp_reg <= bus_req.wdata;
      end
    end
  end

  // Pointer select lives in bit 0 of the auxiliary control register.
  always_comb begin
    sel_next = sel_reg;
    if (byte_wr && bus_req.addr == ADDR_AUX1) begin
      sel_next = bus_req.wdata[AUX_SEL_POS];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= RST_SEL;
    end else begin
      sel_reg <= sel_next;
    end
  end

  // One block per data pointer. A register write in the same cycle as
  // an increment wins, so software always sees the byte it stored.
  genvar g;
  generate
    for (g = 0; g < NUM_PTR; g++) begin : gen_ptr
      always_comb begin
        ptr_next[g] = ptr_reg[g];
        if (sel_reg == 1'(g)) begin
          if (byte_wr && bus_req.addr == ADDR_PTR_LO) begin
            ptr_next[g][7:0] = bus_req.wdata;
          end else if (byte_wr && bus_req.addr == ADDR_PTR_HI) begin
            ptr_next[g][15:8] = bus_req.wdata;
          end else if (data_pointer_primary_inc) begin
            ptr_next[g] = 16'(ptr_reg[g] + PTR_STEP);
          end
        end
      end

      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          ptr_reg[g] <= RST_PTR;
        end else begin
          ptr_reg[g] <= ptr_next[g];
        end
      end
    end
  endgenerate

  // The exported pointer follows the next values so it never lags the
  // select bit or a byte write by a cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_pointer_primary_reg <= RST_PTR;
    end else begin
      data_pointer_primary_reg <= sel_next ? ptr_next[1] : ptr_next[0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_reload_reg <= RST_WAKE;
    end else if (byte_wr && bus_req.addr == ADDR_WAKE) begin
      // An FFH reload at prescale 1/1 is stored as written; the timer
      // cannot honour it, and the check is left to software.
      wake_reload_reg <= bus_req.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port0_reg <= RST_PORT0;
    end else if (byte_wr && bus_req.addr == ADDR_PORT0) begin
      port0_reg <= bus_req.wdata;
    end else if (bit_wr && bit_page == BIT_PAGE_PORT0) begin
      port0_reg[bit_idx] <= bus_req.wdata[0];
    end
  end

  // Pin drive enables start cleared so no pin drives the latch value
  // until software turns the output on.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_oe_reg <= RST_P0_DRIVE;
    end else if (byte_wr && bus_req.addr == ADDR_P0_DRIVE) begin
      p0_oe_reg <= bus_req.wdata;
    end
  end

  assign p2_bit0_val = rpd_fuse_unprog ? 1'b0 : p2_0_pin_in;

  // Read mux. Unmapped addresses and reserved bits read as zero.
  always_comb begin
    rdata_next = BYTE_ZERO;
    if (byte_rd) begin
      unique case (bus_req.addr)
        ADDR_PORT0:    rdata_next = port0_reg;
        ADDR_STACK:    rdata_next = sp_reg;
        ADDR_PTR_LO:   rdata_next = sel_reg ? ptr_reg[1][7:0]
                                            : ptr_reg[0][7:0];
        ADDR_PTR_HI:   rdata_next = sel_reg ? ptr_reg[1][15:8]
                                            : ptr_reg[0][15:8];
        ADDR_WAKE:     rdata_next = wake_reload_reg;
        ADDR_PORT2:    rdata_next[P2_BIT0_POS] = p2_bit0_val;
        ADDR_AUX1:     rdata_next[AUX_SEL_POS] = sel_reg;
        ADDR_P0_DRIVE: rdata_next = p0_oe_reg;
        default:       rdata_next = BYTE_ZERO;
      endcase
    end else if (bit_rd) begin
      if (bit_page == BIT_PAGE_PORT0) begin
        rdata_next[0] = port0_reg[bit_idx];
      end else if (bit_page == BIT_PAGE_PORT2 && bit_idx == '0) begin
        rdata_next[0] = p2_bit0_val;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= BYTE_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  AST_SP_RESET: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> sp_reg == RST_STACK)
    else $error("Stack pointer not 07H after reset.");

  AST_PUSH_ADDR: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    stk_push |=> stk_ram_reg.we && sp_reg == stk_ram_reg.addr &&
      stk_ram_reg.addr == 8'($past(sp_reg) + STACK_STEP) &&
      stk_ram_reg.data == $past(stk_push_data))
    else $error("Push did not store at the incremented address.");

  AST_PTR_PAIR: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (byte_wr && bus_req.addr == ADDR_PTR_HI) |=>
      data_pointer_primary_reg[15:8] == $past(bus_req.wdata) &&
      data_pointer_primary_reg[7:0] == $past(data_pointer_primary_reg[7:0]))
    else $error("High byte write did not form the 16-bit pointer.");

  AST_PTR_SELECT: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (byte_wr && bus_req.addr == ADDR_PTR_LO) |=>
      ptr_reg[!$past(sel_reg)] == $past(ptr_reg[!sel_reg]) &&
      data_pointer_primary_reg == ptr_reg[$past(sel_reg)])
    else $error("Pointer write reached the unselected pointer.");

  AST_PTR_RESET: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> ptr_reg[0] == RST_PTR && ptr_reg[1] == RST_PTR)
    else $error("Data pointers not cleared after reset.");

  AST_WAKE_RW: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (byte_wr && bus_req.addr == ADDR_WAKE) ##1
      (byte_rd && bus_req.addr == ADDR_WAKE) |=>
      rdata_reg == $past(bus_req.wdata, 2))
    else $error("Wake-up reload byte did not read back.");

  AST_P0_RESET: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> port0_reg == RST_PORT0)
    else $error("Port 0 latch not all ones after reset.");

  AST_P0_BIT: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (bit_wr && bit_page == BIT_PAGE_PORT0) |=>
      port0_reg[$past(bit_idx)] == $past(bus_req.wdata[0]) &&
      ((port0_reg ^ $past(port0_reg)) &
        ~(8'h01 << $past(bit_idx))) == BYTE_ZERO)
    else $error("Port 0 bit write hit the wrong bit.");

  AST_OE_RESET: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> p0_oe_reg == RST_P0_DRIVE)
    else $error("Port 0 drivers enabled after reset.");

  AST_P2_READ: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (bus_req.rd && rpd_fuse_unprog &&
      (bus_req.bit_op ? bus_req.addr == {BIT_PAGE_PORT2, 3'h0}
                      : bus_req.addr == ADDR_PORT2)) |=>
      rdata_reg == BYTE_ZERO)
    else $error("Port 2 bit 0 read nonzero with fuse unprogrammed.");

  AST_RSVD: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (byte_rd && bus_req.addr == ADDR_AUX1) |=>
      rdata_reg[7:1] == 7'h00 && rdata_reg[0] == $past(sel_reg))
    else $error("Reserved auxiliary bits read nonzero.");

endmodule : cpb_sfr_bank
